// File: ufc_host.sv
// host processor model driving the parallel register pins
`timescale 1ns/1ps
module ufc_host (
  input wire clock,
  input wire [7:0] dataOut,
  output reg [2:0] addr,
  output reg [7:0] dataIn,
  output reg chanASelN,
  output reg chanBSelN,
  output reg wrN,
  output reg rdN
);
  initial begin
    addr = 3'h0;
    dataIn = 8'h00;
    chanASelN = 1'b1;
    chanBSelN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
  end
  // caller passes level divided by four
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      addr <= a;
      dataIn <= d;
      chanASelN <= 1'b0;
      wrN <= 1'b0;
      repeat (4) @(posedge clock);
      wrN <= 1'b1;
      repeat (4) @(posedge clock);
      chanASelN <= 1'b1;
      // released bus shows the inverse, not a stale copy
      dataIn <= ~d;
      #2;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge clock);
      addr <= a;
      chanASelN <= 1'b0;
      rdN <= 1'b0;
      repeat (5) @(posedge clock);
      // sample away from the edge that refreshes the registered read data
      @(negedge clock);
      d = dataOut;
      @(posedge clock);
      rdN <= 1'b1;
      chanASelN <= 1'b1;
      repeat (4) @(posedge clock);
      #2;
    end
  endtask
endmodule

// File: ufc_map.vh
// register offsets, field positions, reset values and trigger codes of the flow-control bank
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// ==================================================
// register offsets on the three address pins
`define UFC_ADDR_DIV_LOW 3'h0
`define UFC_ADDR_DIV_HIGH 3'h1
`define UFC_ADDR_INT_EN 3'h1
`define UFC_ADDR_FIFO_CTRL 3'h2
`define UFC_ADDR_INT_ID 3'h2
`define UFC_ADDR_ENH_FEAT 3'h2
`define UFC_ADDR_LINE_CTRL 3'h3
`define UFC_ADDR_MODEM_CTRL 3'h4
`define UFC_ADDR_FLOW_LVL 3'h6
`define UFC_ADDR_TRIG_LVL 3'h7
`define UFC_ADDR_FIFO_RDY 3'h7

// ==================================================
// access keys and field positions
`define UFC_LINE_ENH_KEY 8'hBF
`define UFC_LINE_DIV_BIT 7
`define UFC_ENHF_ENABLE_BIT 4
`define UFC_ENHF_SPECIAL_BIT 5
`define UFC_ENHF_AUTO_RTS_BIT 6
`define UFC_ENHF_AUTO_CTS_BIT 7
`define UFC_INTEN_SLEEP_BIT 4
`define UFC_MODEM_RTS_BIT 1
`define UFC_MODEM_RDY_EN_BIT 2
`define UFC_MODEM_LOOP_BIT 4
`define UFC_MODEM_LVL_ACC_BIT 6
`define UFC_FIFO_EN_BIT 0

// ==================================================
// reset values
`define UFC_RST_BYTE 8'h00

// ==================================================
// fifo-control trigger selections, in characters
`define UFC_TX_TRIG_0 7'h08
`define UFC_TX_TRIG_1 7'h10
`define UFC_TX_TRIG_2 7'h20
`define UFC_TX_TRIG_3 7'h38
`define UFC_RX_TRIG_0 7'h08
`define UFC_RX_TRIG_1 7'h10
`define UFC_RX_TRIG_2 7'h38
`define UFC_RX_TRIG_3 7'h3C

`endif

// File: ufc_regs.v
// flow-control, divisor, trigger-level and fifo-ready register bank for two serial channels
// Function
// RQ1: low four enhanced-feature bits select software flow control combination.
// RQ2: enhanced-enable bit gates writes to upper enable, fifo-control and modem bits.
// RQ3: special detect compares received characters with second xoff, flags identification bit.
// RQ4: auto request-to-send rises at halt level, falls at restore level.
// RQ5: auto clear-to-send stops new transmissions while the input is high.
// RQ6: divisor is high latch byte over low latch byte.
// RQ7: divisor latches are writable only while sleep enable is clear.
// RQ8: flow level nibbles are receive levels 0 to 60 in steps of four.
// RQ9: flow level register writable only with enhanced-enable and level-access bit set.
// RQ10: host keeps halt above restore before enabling flow control.
// RQ11: trigger nibbles give transmit spaces and receive characters as level divided by four.
// RQ12: trigger level register writable only with enhanced-enable and level-access bit set.
// RQ13: a zero trigger nibble falls back to the fifo-control selected level.
// RQ14: ready bits 0 and 1 show enough transmit spaces; bits 3:2, 7:6 zero.
// RQ15: ready bits 4 and 5 show receive above trigger or timeout.
// RQ16: ready register read-only at address 7 with ready-enable set, no loopback.
// RQ17: level-access bit opens flow and trigger level registers, clearing restores normal map.
// RQ18: ready bits come live from current occupancy and thresholds.
`timescale 1ns/1ps
`include "ufc_map.vh"

module ufc_regs #(
  parameter NCH = 2
) (
  input wire clock,
  input wire nrst,
  input wire [2:0] addr,
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output wire dataOe,
  input wire chanASelN,
  input wire chanBSelN,
  input wire wrN,
  input wire rdN,
  input wire [2*NCH-1:0] ctsN,
  output wire [NCH-1:0] rtsN,
  input wire [7*NCH-1:0] txSpaces,
  input wire [7*NCH-1:0] rxCount,
  input wire [NCH-1:0] rxTimeout,
  input wire [8*NCH-1:0] rxChar,
  input wire [NCH-1:0] rxCharValid,
  input wire [8*NCH-1:0] xoff2Char,
  output wire [NCH-1:0] txHalt,
  output wire [NCH-1:0] specialDet,
  output wire [16*NCH-1:0] baudDivisor,
  output wire [4*NCH-1:0] swFlowSel,
  output wire [7*NCH-1:0] txTrigLevel,
  output wire [7*NCH-1:0] rxTrigLevel
);

  // ==================================================
  // decoding used by every channel
  function [6:0] txSelLevel;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: txSelLevel = `UFC_TX_TRIG_0;
        2'h1: txSelLevel = `UFC_TX_TRIG_1;
        2'h2: txSelLevel = `UFC_TX_TRIG_2;
        default: txSelLevel = `UFC_TX_TRIG_3;
      endcase
    end
  endfunction

  function [6:0] rxSelLevel;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: rxSelLevel = `UFC_RX_TRIG_0;
        2'h1: rxSelLevel = `UFC_RX_TRIG_1;
        2'h2: rxSelLevel = `UFC_RX_TRIG_2;
        default: rxSelLevel = `UFC_RX_TRIG_3;
      endcase
    end
  endfunction

  // nibble times four, the register holds the level divided by four
  function [6:0] lvl4;
    input [3:0] nib;
    begin
      lvl4 = {1'b0, nib, 2'b00};
    end
  endfunction

  // ==================================================
  // host pin synchronisers
  // the bus pins are asynchronous to the clock; every pin passes two flops, the write strobe three
  reg [2:0] addrS1_q, addrS2_q;
  reg [7:0] dataS1_q, dataS2_q;
  reg [1:0] csS1_q, csS2_q;
  reg wrS1_q, wrS2_q, wrS3_q;
  reg rdS1_q, rdS2_q;

  always @(posedge clock) begin
    if (!nrst) begin
      addrS1_q <= 3'h0;
      addrS2_q <= 3'h0;
      dataS1_q <= 8'h00;
      dataS2_q <= 8'h00;
      csS1_q <= 2'h3;
      csS2_q <= 2'h3;
      wrS1_q <= 1'b1;
      wrS2_q <= 1'b1;
      wrS3_q <= 1'b1;
      rdS1_q <= 1'b1;
      rdS2_q <= 1'b1;
    end else begin
      addrS1_q <= addr;
      addrS2_q <= addrS1_q;
      dataS1_q <= dataIn;
      dataS2_q <= dataS1_q;
      csS1_q <= {chanBSelN, chanASelN};
      csS2_q <= csS1_q;
      wrS1_q <= wrN;
      wrS2_q <= wrS1_q;
      wrS3_q <= wrS2_q;
      rdS1_q <= rdN;
      rdS2_q <= rdS1_q;
    end
  end

  // write is taken at the trailing (rising) edge of the strobe, when data has settled
  wire wrStrobe = wrS2_q & ~wrS3_q;
  wire rdActive = ~rdS2_q & ~(csS2_q[0] & csS2_q[1]);
  // channel A wins if both selects are low
  wire chanB = csS2_q[0];
  assign dataOe = rdActive;

  wire [7:0] chRd [0:NCH-1];
  wire [NCH-1:0] rdyOk;
  wire [NCH-1:0] txRdy;
  wire [NCH-1:0] rxRdy;
  wire [NCH-1:0] idRead;

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : gCh
      reg [7:0] enhFeat_q, divLow_q, divHigh_q, flowLvl_q, trigLvl_q;
      reg [7:0] intEn_q, fifoCtl_q, lineCtl_q, modemCtl_q;
      reg [1:0] ctsS_q;
      reg rtsHigh_q, special_q, idRd_q;
      reg [7:0] rd;
      wire [6:0] rxCnt = rxCount[7*i +: 7];
      wire [6:0] txSp = txSpaces[7*i +: 7];
      wire wrEn = wrStrobe & ~csS2_q[i] & (i == 0 || csS2_q[0]);
      wire enhKey = (lineCtl_q == `UFC_LINE_ENH_KEY);
      wire divAcc = lineCtl_q[`UFC_LINE_DIV_BIT];
      wire enh = enhFeat_q[`UFC_ENHF_ENABLE_BIT];
      // level-access needs both the enhanced gate and the access bit
      wire lvlAcc = enh & modemCtl_q[`UFC_MODEM_LVL_ACC_BIT] & ~divAcc;
      wire [6:0] txTrig;
      wire [6:0] rxTrig;

      // RQ11 nibble times four
      // RQ13 zero falls back
      assign txTrig = (trigLvl_q[3:0] != 4'h0) ? lvl4(trigLvl_q[3:0])
        : txSelLevel(fifoCtl_q[5:4]);
      assign rxTrig = (trigLvl_q[7:4] != 4'h0) ? lvl4(trigLvl_q[7:4])
        : rxSelLevel(fifoCtl_q[7:6]);
      assign txTrigLevel[7*i +: 7] = txTrig;
      assign rxTrigLevel[7*i +: 7] = rxTrig;

      // RQ14 transmit space ready
      assign txRdy[i] = (txSp >= txTrig);
      // RQ15 receive ready or timeout
      assign rxRdy[i] = (rxCnt > rxTrig) | rxTimeout[i];
      // RQ16 ready register enable
      assign rdyOk[i] = modemCtl_q[`UFC_MODEM_RDY_EN_BIT] & ~modemCtl_q[`UFC_MODEM_LOOP_BIT]
        & ~lvlAcc & ~divAcc & ~enhKey;

      // RQ6 divisor concatenation
      assign baudDivisor[16*i +: 16] = {divHigh_q, divLow_q};
      // RQ1 software flow select
      assign swFlowSel[4*i +: 4] = enhFeat_q[3:0];
      // RQ5 auto cts halt
      assign txHalt[i] = enhFeat_q[`UFC_ENHF_AUTO_CTS_BIT] & ctsS_q[1];
      // RQ4 rts pin, high is inactive
      assign rtsN[i] = enhFeat_q[`UFC_ENHF_AUTO_RTS_BIT] ? rtsHigh_q
        : ~modemCtl_q[`UFC_MODEM_RTS_BIT];
      assign specialDet[i] = special_q;
      assign idRead[i] = rdActive & (chanB == (i == 1)) & ~enhKey & ~divAcc
        & (addrS2_q == `UFC_ADDR_INT_ID);

      always @(posedge clock) begin
        if (!nrst) begin
          ctsS_q <= 2'h0;
        end else begin
          ctsS_q <= {ctsS_q[0], ctsN[2*i]};
        end
      end

      always @(posedge clock) begin
        if (!nrst) begin
          enhFeat_q <= `UFC_RST_BYTE;
          divLow_q <= `UFC_RST_BYTE;
          divHigh_q <= `UFC_RST_BYTE;
          flowLvl_q <= `UFC_RST_BYTE;
          trigLvl_q <= `UFC_RST_BYTE;
          intEn_q <= `UFC_RST_BYTE;
          fifoCtl_q <= `UFC_RST_BYTE;
          lineCtl_q <= `UFC_RST_BYTE;
          modemCtl_q <= `UFC_RST_BYTE;
        end else if (wrEn) begin
          if (addrS2_q == `UFC_ADDR_LINE_CTRL) begin
            lineCtl_q <= dataS2_q;
          end else if (enhKey) begin
            if (addrS2_q == `UFC_ADDR_ENH_FEAT) begin
              enhFeat_q <= dataS2_q;
            end
          end else if (divAcc) begin
            // RQ7 sleep blocks divisor
            if (addrS2_q == `UFC_ADDR_DIV_LOW && !intEn_q[`UFC_INTEN_SLEEP_BIT]) begin
              divLow_q <= dataS2_q;
            end
            if (addrS2_q == `UFC_ADDR_DIV_HIGH && !intEn_q[`UFC_INTEN_SLEEP_BIT]) begin
              divHigh_q <= dataS2_q;
            end
          end else begin
            case (addrS2_q)
              `UFC_ADDR_INT_EN: begin
                // RQ2 gated upper enables
                intEn_q <= {enh ? dataS2_q[7:4] : intEn_q[7:4], dataS2_q[3:0]};
              end
              `UFC_ADDR_FIFO_CTRL: begin
                // RQ2 gated fifo bits
                fifoCtl_q <= {dataS2_q[7:6], enh ? dataS2_q[5:4] : fifoCtl_q[5:4], dataS2_q[3:0]};
              end
              `UFC_ADDR_MODEM_CTRL: begin
                // RQ2 gated modem bits
                modemCtl_q <= {enh ? dataS2_q[7:5] : modemCtl_q[7:5], dataS2_q[4:0]};
              end
              `UFC_ADDR_FLOW_LVL: begin
                // RQ9 flow level write gate
                if (lvlAcc) begin
                  flowLvl_q <= dataS2_q;
                end
              end
              `UFC_ADDR_TRIG_LVL: begin
                // RQ12 trigger level write gate
                if (lvlAcc) begin
                  trigLvl_q <= dataS2_q;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end

      // RQ4 halt/restore hysteresis
      // RQ8 nibble levels in steps of four
      always @(posedge clock) begin
        if (!nrst) begin
          rtsHigh_q <= 1'b0;
        end else if (rxCnt >= lvl4(flowLvl_q[3:0])) begin
          rtsHigh_q <= 1'b1;
        end else if (rxCnt <= lvl4(flowLvl_q[7:4])) begin
          rtsHigh_q <= 1'b0;
        end
      end

      // RQ3 special character flag
      // cleared as an identification read ends, so the host still sees it; a match wins
      always @(posedge clock) begin
        if (!nrst) begin
          special_q <= 1'b0;
          idRd_q <= 1'b0;
        end else begin
          idRd_q <= idRead[i];
          if (enhFeat_q[`UFC_ENHF_SPECIAL_BIT] & rxCharValid[i]
              & (rxChar[8*i +: 8] == xoff2Char[8*i +: 8])) begin
            special_q <= 1'b1;
          end else if (idRd_q & ~idRead[i]) begin
            special_q <= 1'b0;
          end
        end
      end

      always @* begin
        rd = 8'h00;
        if (addrS2_q == `UFC_ADDR_LINE_CTRL) begin
          rd = lineCtl_q;
        end else if (enhKey) begin
          if (addrS2_q == `UFC_ADDR_ENH_FEAT) begin
            rd = enhFeat_q;
          end
        end else if (divAcc) begin
          if (addrS2_q == `UFC_ADDR_DIV_LOW) begin
            rd = divLow_q;
          end else if (addrS2_q == `UFC_ADDR_DIV_HIGH) begin
            rd = divHigh_q;
          end
        end else begin
          case (addrS2_q)
            `UFC_ADDR_INT_EN: rd = intEn_q;
            `UFC_ADDR_INT_ID: begin
              rd = {{2{fifoCtl_q[`UFC_FIFO_EN_BIT]}}, 1'b0, special_q, 3'h0, ~special_q};
            end
            `UFC_ADDR_MODEM_CTRL: rd = modemCtl_q;
            // RQ17 level access remaps 6 and 7
            `UFC_ADDR_FLOW_LVL: rd = lvlAcc ? flowLvl_q : 8'h00;
            `UFC_ADDR_TRIG_LVL: rd = lvlAcc ? trigLvl_q : 8'h00;
            default: rd = 8'h00;
          endcase
        end
      end
      assign chRd[i] = rd;
    end
  endgenerate

  // ==================================================
  // read data path
  wire rdyHere = (addrS2_q == `UFC_ADDR_FIFO_RDY) & rdyOk[chanB];

  // RQ18 live ready bits, no latching
  // RQ14 unused bits zero
  wire [7:0] fifo_ready_status = {2'b00, rxRdy[1], rxRdy[0], 2'b00, txRdy[1], txRdy[0]};

  // data is re-sampled every cycle of the read so the host sees current state
  always @(posedge clock) begin
    if (!nrst) begin
      dataOut <= 8'h00;
    end else if (rdActive) begin
      // RQ16 ready register at address 7
      dataOut <= rdyHere ? fifo_ready_status : (chanB ? chRd[1] : chRd[0]);
    end
  end

endmodule

// File: ufc_regs_sva.sv
// assertion checker for the flow-control register bank
`timescale 1ns/1ps
module ufc_regs_sva #(
  parameter NCH = 2
) (
  input wire clock,
  input wire nrst,
  input wire chanASelN,
  input wire wrN,
  input wire rdN,
  input wire dataOe,
  input wire [2*NCH-1:0] ctsN,
  input wire [NCH-1:0] txHalt,
  input wire [NCH-1:0] rxCharValid,
  input wire [NCH-1:0] specialDet,
  input wire [16*NCH-1:0] baudDivisor,
  input wire [4*NCH-1:0] swFlowSel,
  input wire [7*NCH-1:0] txTrigLevel,
  input wire [7*NCH-1:0] rxTrigLevel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  oe_cause_a: assert property (dataOe |-> !$past(rdN, 2))
    else $error("data bus driven without a read");
  oe_answer_a: assert property ((!rdN && !chanASelN) [*3] |-> dataOe)
    else $error("read not answered in time");
  halt_cause_a: assert property (txHalt[0] |-> $past(ctsN[0], 2) || $past(ctsN[0], 3))
    else $error("channel a halted with cts low");
  halt_cause_b: assert property (txHalt[1] |-> $past(ctsN[2], 2) || $past(ctsN[2], 3))
    else $error("channel b halted with cts low");
  special_cause_a: assert property ($rose(specialDet[0]) |->
    $past(rxCharValid[0]) || $past(rxCharValid[0], 2))
    else $error("special flag without a received character");
  tx_trig_a: assert property (txTrigLevel[1:0] == 2'h0 && txTrigLevel[6:0] != 7'h00
    && txTrigLevel[6:0] <= 7'h3C)
    else $error("transmit trigger level out of range");
  rx_trig_a: assert property (rxTrigLevel[1:0] == 2'h0 && rxTrigLevel[6:0] != 7'h00
    && rxTrigLevel[6:0] <= 7'h3C)
    else $error("receive trigger level out of range");
  cfg_write_a: assert property ($changed({baudDivisor, swFlowSel}) |->
    $past(wrN, 1) && $past(wrN, 2))
    else $error("configuration changed without a write");
endmodule
bind ufc_regs ufc_regs_sva #(.NCH(NCH)) u_sva (.clock(clock), .nrst(nrst),
  .chanASelN(chanASelN), .wrN(wrN), .rdN(rdN), .dataOe(dataOe), .ctsN(ctsN),
  .txHalt(txHalt), .rxCharValid(rxCharValid), .specialDet(specialDet),
  .baudDivisor(baudDivisor), .swFlowSel(swFlowSel), .txTrigLevel(txTrigLevel),
  .rxTrigLevel(rxTrigLevel));

// File: ufc_regs_tb.sv
// self-checking testbench of the flow-control register bank
`timescale 1ns/1ps
module ufc_regs_tb;
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] ctsN = 4'h0;
  reg [13:0] txSpaces = 14'h0000;
  reg [13:0] rxCount = 14'h0000;
  reg [1:0] rxTimeout = 2'h0;
  reg [15:0] rxChar = 16'h0000;
  reg [1:0] rxCharValid = 2'h0;
  reg [15:0] xoff2Char = 16'h1113;
  wire [2:0] addr;
  wire [7:0] dataIn, dataOut;
  wire dataOe, chanASelN, chanBSelN, wrN, rdN;
  wire [1:0] rtsN, txHalt, specialDet;
  wire [31:0] baudDivisor;
  wire [7:0] swFlowSel;
  wire [13:0] txTrigLevel, rxTrigLevel;
  integer seed = 35;
  integer miscompares = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  reg [7:0] lo, hi, rb;
  reg [3:0] tn, rn;
  always #5 clock = ~clock;
  ufc_host u_host (.clock(clock), .dataOut(dataOut), .addr(addr), .dataIn(dataIn),
    .chanASelN(chanASelN), .chanBSelN(chanBSelN), .wrN(wrN), .rdN(rdN));
  ufc_regs #(.NCH(2)) u_dut (.clock(clock), .nrst(nrst), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .chanASelN(chanASelN), .chanBSelN(chanBSelN),
    .wrN(wrN), .rdN(rdN), .ctsN(ctsN), .rtsN(rtsN), .txSpaces(txSpaces),
    .rxCount(rxCount), .rxTimeout(rxTimeout), .rxChar(rxChar), .rxCharValid(rxCharValid),
    .xoff2Char(xoff2Char), .txHalt(txHalt), .specialDet(specialDet),
    .baudDivisor(baudDivisor), .swFlowSel(swFlowSel), .txTrigLevel(txTrigLevel),
    .rxTrigLevel(rxTrigLevel));
  task stop_test;
    begin
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #2;
    end
  endtask
  // channel b keeps the fifo-control default of eight
  function [7:0] rdy(input [6:0] ta, input [6:0] ra);
    begin
      rdy = 8'h00;
      rdy[0] = txSpaces[6:0] >= ta;
      rdy[1] = txSpaces[13:7] >= 7'h08;
      rdy[4] = rxCount[6:0] > ra || rxTimeout[0];
      rdy[5] = rxCount[13:7] > 7'h08 || rxTimeout[1];
    end
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    tick(3);
    u_host.wr(3'h3, 8'hBF);
    u_host.wr(3'h2, 8'h10);
    u_host.wr(3'h3, 8'h03);
    u_host.wr(3'h4, 8'h44);
    u_host.wr(3'h6, 8'h2A);
    u_host.wr(3'h3, 8'hBF);
    u_host.wr(3'h2, 8'hF5);
    chk(swFlowSel[3:0], 4'h5);
    u_host.rd(3'h2, rb);
    chk(rb, 8'hF5);
    lo = $random(seed);
    hi = $random(seed);
    // divisor latches are only mapped with the divisor-access bit and no enhanced key
    u_host.wr(3'h3, 8'h83);
    u_host.wr(3'h0, lo);
    u_host.wr(3'h1, hi);
    chk(baudDivisor[15:0], {hi, lo});
    u_host.wr(3'h3, 8'h03);
    chk(txTrigLevel[6:0], 7'h08);
    chk(rxTrigLevel[13:7], 7'h08);
    for (i = 0; i < 3; i = i + 1) begin
      rb = $random(seed);
      tn = rb[3:0] | 4'h1;
      rn = rb[7:4] | 4'h1;
      u_host.wr(3'h7, {rn, tn});
      chk(txTrigLevel[6:0], {tn, 2'h0});
      chk(rxTrigLevel[6:0], {rn, 2'h0});
    end
    @(posedge clock) rxCount[6:0] <= 7'h28;
    tick(3);
    chk(rtsN[0], 1'b1);
    @(posedge clock) rxCount[6:0] <= 7'h14;
    tick(3);
    chk(rtsN[0], 1'b1);
    @(posedge clock) rxCount[6:0] <= 7'h08;
    tick(3);
    chk(rtsN[0], 1'b0);
    @(posedge clock) ctsN[0] <= 1'b1;
    tick(4);
    chk(txHalt[0], 1'b1);
    @(posedge clock) ctsN[0] <= 1'b0;
    tick(4);
    chk(txHalt[0], 1'b0);
    @(posedge clock) rxChar[7:0] <= 8'h13;
    rxCharValid[0] <= 1'b1;
    @(posedge clock) rxCharValid[0] <= 1'b0;
    tick(2);
    chk(specialDet[0], 1'b1);
    u_host.rd(3'h2, rb);
    chk(rb, 8'h10);
    chk(specialDet[0], 1'b0);
    u_host.wr(3'h4, 8'h04);
    u_host.wr(3'h7, 8'hFF);
    chk(txTrigLevel[6:0], {tn, 2'h0});
    for (i = 0; i < 6; i = i + 1) begin
      // first pass sits exactly on both thresholds
      @(posedge clock) txSpaces <= i == 0 ? {7'h08, 1'b0, tn, 2'h0} : $random(seed) & 14'h1FBF;
      rxCount <= i == 0 ? {7'h08, 1'b0, rn, 2'h0} : $random(seed) & 14'h1FBF;
      rxTimeout <= i == 0 ? 2'h0 : $random(seed);
      u_host.rd(3'h7, rb);
      chk(rb, rdy({tn, 2'h0}, {rn, 2'h0}));
    end
    u_host.wr(3'h4, 8'h00);
    u_host.rd(3'h7, rb);
    chk(rb, 8'h00);
    u_host.wr(3'h1, 8'h10);
    u_host.wr(3'h3, 8'h83);
    u_host.wr(3'h0, ~lo);
    chk(baudDivisor[15:0], {hi, lo});
    stop_test;
  end
endmodule
